// >>> verilog/torque_disable_pkg.sv
// package for the dual-channel torque disable block
// assumes one 250 MHz clock and a synchronous power-on reset
`default_nettype none
package torque_disable_pkg;
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned IMMUNITY_US        = 2000;
  localparam int unsigned REACTION_US        = 6000;
  localparam int unsigned FAULT_MIN_MS       = 1600;
  localparam int unsigned FAULT_MAX_MS       = 3000;
  localparam int unsigned FAULT_TYP_MS       = 2300;
  // filter delay: above immunity width, at the typical reaction time
  localparam int unsigned REACTION_CYCLES    = REACTION_US * CLK_MHZ;
  localparam int unsigned IMMUNITY_CYCLES    = IMMUNITY_US * CLK_MHZ;
  localparam int unsigned FAULT_TYP_CYCLES   = FAULT_TYP_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAULT_MIN_CYCLES   = FAULT_MIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAULT_MAX_CYCLES   = FAULT_MAX_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_TRIP  = 3'b010,
    ST_FAULT = 3'b100
  } td_state_t;

  typedef struct packed {
    logic drive_enable;
    logic trip;
    logic safe_indicator;
    logic fault_latched;
  } td_status_t;
endpackage : torque_disable_pkg
`default_nettype wire

// >>> verilog/dual_channel_torque_disable.sv
// dual-channel torque disable: filters two stop inputs, times disagreement
// assumes stop inputs synchronous to ref_clk; rst is the power-on reset only
// Function
// RL1: channel A low disables drive
// RL2: run only when both inputs high
// RL3: indicator on in safe state
// RL4: both low: trip, indicator on; the code keeps the indicator off once the fault is latched
// RL5: one low: trip, indicator off
// RL6: disagreement past maximum time latches fault
// RL7: fault cleared only by power cycle
// RL8: no fault below minimum disagreement time
// RL9: disagreement means inputs in opposite states
// RL10: both high: enable run, indicator off
// RL11: indicator tracks inputs on auxiliary supply
// RL12: indicator is indication only, not proof
// RL13: ignore low pulses shorter than immunity width
// RL14: react after input low for reaction time
// RL15: timer restarts when channels agree again
`timescale 1ns/1ns
`default_nettype none
module dual_channel_torque_disable
  import torque_disable_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = REACTION_CYCLES,
  parameter int unsigned FAULT_CYCLES  = FAULT_TYP_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic channel_a_stop_input,
  input  wire logic channel_b_stop_input,
  output var  logic drive_enable,
  output var  logic trip,
  output var  logic safe_indicator,
  output var  logic fault_latched
);
  localparam int FW = $clog2(FILTER_CYCLES + 1);
  localparam int TW = $clog2(FAULT_CYCLES + 1);

  // refuse counts that the filter and the fault timer cannot serve
  if (FILTER_CYCLES < 1) begin : g_bad_filter
    $error("FILTER_CYCLES must be at least 1");
  end
  // a fault time beyond the maximum would let a disagreement run on unlatched
  if (FAULT_CYCLES < 2 || FAULT_CYCLES > FAULT_MAX_CYCLES) begin : g_bad_fault
    $error("FAULT_CYCLES out of range");
  end

  logic [FW-1:0] low_cnt_a;
  logic [FW-1:0] low_cnt_b;
  logic [FW-1:0] next_low_cnt_a;
  logic [FW-1:0] next_low_cnt_b;
  logic          filt_a;
  logic          filt_b;
  logic          next_filt_a;
  logic          next_filt_b;
  logic [TW-1:0] dis_cnt;
  logic [TW-1:0] next_dis_cnt;
  td_state_t     state;
  td_state_t     next_state;
  td_status_t    status;
  td_status_t    next_status;

  // input filters: a low must persist FILTER_CYCLES before it counts
  always_comb begin
    next_low_cnt_a = '0;
    next_low_cnt_b = '0;
    next_filt_a    = 1'b1;
    next_filt_b    = 1'b1;
    if (!channel_a_stop_input) begin
      next_low_cnt_a = (low_cnt_a == FW'(FILTER_CYCLES)) ? low_cnt_a : low_cnt_a + 1'b1; // RL13
      next_filt_a    = (low_cnt_a != FW'(FILTER_CYCLES)); // RL14
    end
    if (!channel_b_stop_input) begin
      next_low_cnt_b = (low_cnt_b == FW'(FILTER_CYCLES)) ? low_cnt_b : low_cnt_b + 1'b1; // RL13
      next_filt_b    = (low_cnt_b != FW'(FILTER_CYCLES)); // RL14
    end
  end

  // disagreement timer and state
  always_comb begin
    next_dis_cnt = '0;
    next_state   = state;
    if (filt_a != filt_b) begin // RL9
      next_dis_cnt = dis_cnt + 1'b1;
    end // RL15
    unique case (state)
      ST_RUN:   if (!(filt_a && filt_b)) next_state = ST_TRIP; // RL1
      ST_TRIP: begin
        if (dis_cnt == TW'(FAULT_CYCLES - 1)) next_state = ST_FAULT; // RL6 RL8
        else if (filt_a && filt_b) next_state = ST_RUN; // RL2
      end
      ST_FAULT: next_state = ST_FAULT; // RL7
      default:  next_state = ST_FAULT;
    endcase
    if (next_state == ST_FAULT) next_dis_cnt = '0;
  end

  // outputs, computed from next state so they change in the same cycle as state
  always_comb begin
    next_status.drive_enable   = (next_state == ST_RUN); // RL10
    next_status.trip           = (next_state != ST_RUN); // RL4 RL5
    next_status.fault_latched  = (next_state == ST_FAULT);
    // indicator independent of main power, only both-low outside fault
    next_status.safe_indicator = (next_state == ST_TRIP) && !next_filt_a && !next_filt_b
                                 && !(filt_a != filt_b); // RL3 RL11
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // counters start saturated so the filters come out of reset low (safe)
      low_cnt_a <= FW'(FILTER_CYCLES);
      low_cnt_b <= FW'(FILTER_CYCLES);
      filt_a    <= 1'b0;
      filt_b    <= 1'b0;
      dis_cnt   <= '0;
      state     <= ST_TRIP;
      status    <= '{drive_enable: 1'b0, trip: 1'b1, safe_indicator: 1'b0,
                     fault_latched: 1'b0};
    end else begin
      low_cnt_a <= next_low_cnt_a;
      low_cnt_b <= next_low_cnt_b;
      filt_a    <= next_filt_a;
      filt_b    <= next_filt_b;
      dis_cnt   <= next_dis_cnt;
      state     <= next_state;
      status    <= next_status;
    end
  end

  assign drive_enable   = status.drive_enable;
  assign trip           = status.trip;
  assign safe_indicator = status.safe_indicator;
  assign fault_latched  = status.fault_latched;

  // checking aid: consecutive cycles of filtered disagreement, saturating
  logic [TW-1:0] dis_run;
  logic [TW-1:0] next_dis_run;

  always_comb begin
    next_dis_run = '0;
    if (filt_a != filt_b) begin
      next_dis_run = (dis_run == TW'(FAULT_CYCLES)) ? dis_run : dis_run + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dis_run <= '0;
    end else begin
      dis_run <= next_dis_run;
    end
  end

  // run permission
  // drive_enable follows the filters one register late
  a_run_needs_both: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    drive_enable |-> $past(filt_a) && $past(filt_b) && state == ST_RUN)
    else $error("drive enabled without both inputs high");
  a_run_entry: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    $rose(drive_enable) |-> $past(filt_a) && $past(filt_b))
    else $error("run entered without both inputs high");
  a_b_low_stops: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    !filt_b |=> !drive_enable)
    else $error("drive enabled with channel b low");
  a_trip_vs_run: assert property (@(posedge ref_clk) disable iff (rst) // RL1
    trip != drive_enable)
    else $error("trip and drive enable agree");

  // fault latch, disagreement timer and channel a stop
  a_fault_state: assert property (@(posedge ref_clk) disable iff (rst) // RL7
    (state == ST_FAULT) |=> state == ST_FAULT)
    else $error("fault state left");
  a_fault_quiet: assert property (@(posedge ref_clk) disable iff (rst) // RL7
    fault_latched |-> !safe_indicator && !drive_enable)
    else $error("outputs active in fault");
  a_a_low_stops: assert property (@(posedge ref_clk) disable iff (rst) // RL1
    !filt_a |=> !drive_enable)
    else $error("drive enabled with channel a low");
  a_fault_sticks: assert property (@(posedge ref_clk) disable iff (rst) // RL7
    fault_latched |=> fault_latched && !drive_enable && trip)
    else $error("fault latch released");
  a_fault_timing: assert property (@(posedge ref_clk) disable iff (rst) // RL6
    $rose(state == ST_FAULT) |-> $past(dis_cnt) == TW'(FAULT_CYCLES - 1))
    else $error("fault latched at wrong count");
  a_fault_min: assert property (@(posedge ref_clk) disable iff (rst) // RL8
    $rose(state == ST_FAULT) |-> $past(dis_run) >= TW'(FAULT_CYCLES - 1))
    else $error("fault time below minimum");
  a_timer_reset: assert property (@(posedge ref_clk) disable iff (rst) // RL15
    (filt_a == filt_b) |=> dis_cnt == '0)
    else $error("timer not cleared on agreement");

  // safe-state indicator
  a_ind_both_low: assert property (@(posedge ref_clk) disable iff (rst) // RL4
    (!next_filt_a && !next_filt_b && !filt_a && !filt_b && next_state == ST_TRIP)
    |=> safe_indicator && trip)
    else $error("both low without indicator");
  a_ind_one_low: assert property (@(posedge ref_clk) disable iff (rst) // RL5
    (filt_a != filt_b) |=> !safe_indicator && trip)
    else $error("indicator on during disagreement");
  a_ind_both_high: assert property (@(posedge ref_clk) disable iff (rst) // RL10
    drive_enable |-> !safe_indicator)
    else $error("indicator on while running");
  a_ind_both_up: assert property (@(posedge ref_clk) disable iff (rst) // RL10
    (filt_a && filt_b) |=> !safe_indicator)
    else $error("indicator on with both inputs high");
  a_safe_needs_low: assert property (@(posedge ref_clk) disable iff (rst) // RL3
    safe_indicator |-> !filt_a && !filt_b)
    else $error("indicator on without both inputs low");

  // input filters: a low shorter than the filter span never reaches them
  a_pulse_immune: assert property (@(posedge ref_clk) disable iff (rst) // RL13
    (filt_a && !channel_a_stop_input && low_cnt_a != FW'(FILTER_CYCLES)) |=> filt_a)
    else $error("short low pulse reached filter a");
  a_pulse_immune_b: assert property (@(posedge ref_clk) disable iff (rst) // RL13
    (filt_b && !channel_b_stop_input && low_cnt_b != FW'(FILTER_CYCLES)) |=> filt_b)
    else $error("short low pulse reached filter b");
endmodule : dual_channel_torque_disable
`default_nettype wire

// >>> bench/stop_source.sv
// partner model: two independent relay contacts feeding the stop inputs
// assumes the bench sets the wanted levels just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module stop_source (
  input  wire logic ref_clk,
  input  wire logic want_a,
  input  wire logic want_b,
  output var  logic chan_a,
  output var  logic chan_b
);
  initial {chan_a, chan_b} = 2'b00;
  // contacts switch on the falling edge; the indicator is never read back
  always @(negedge ref_clk) begin
    chan_a <= want_a;
    chan_b <= want_b;
  end
endmodule : stop_source
`default_nettype wire

// >>> bench/tb_top.sv
// bench for the dual-channel torque disable block, shortened counts
// assumes the partner model drives both stop inputs at the falling edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] %s exp %h got %h", what, exp, got); end end
module tb_top;
  import torque_disable_pkg::*;
  typedef struct { logic a; logic b; td_status_t exp; } row_t;
  logic ref_clk, rst, want_a, want_b, chan_a, chan_b;
  wire td_status_t st;
  int fails, checks_done;
  row_t rows[6] = '{'{1, 1, 4'h8}, '{0, 1, 4'h4}, '{1, 1, 4'h8},
                    '{1, 0, 4'h4}, '{0, 0, 4'h6}, '{1, 1, 4'h8}};
  dual_channel_torque_disable #(.FILTER_CYCLES(4), .FAULT_CYCLES(20)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .channel_a_stop_input(chan_a),
    .channel_b_stop_input(chan_b), .drive_enable(st.drive_enable), .trip(st.trip),
    .safe_indicator(st.safe_indicator), .fault_latched(st.fault_latched));
  stop_source partner_u (.ref_clk(ref_clk), .want_a(want_a), .want_b(want_b),
    .chan_a(chan_a), .chan_b(chan_b));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task step(input logic a, input logic b, input int n);
    @(posedge ref_clk);
    want_a = a;
    want_b = b;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    rst = 1;
    want_a = 0;
    want_b = 0;
    fails = 0;
    checks_done = 0;
    repeat (10) @(negedge ref_clk);
    rst = 0;
    `CHK("reset", 4'h4, st)
    foreach (rows[i]) begin
      step(rows[i].a, rows[i].b, 10);
      `CHK("table", rows[i].exp, st)
    end
    $display("table done");
    step(0, 1, 3);
    `CHK("pulse", 4'h8, st)
    step(1, 1, 3);
    `CHK("pulse end", 4'h8, st)
    step(0, 1, 8);
    `CHK("react", 4'h4, st)
    $display("filter done");
    step(1, 1, 10);
    step(1, 0, 14);
    step(1, 1, 2);
    step(1, 0, 14);
    `CHK("short skew", 4'h4, st)
    step(1, 0, 40);
    `CHK("fault", 4'h5, st)
    step(0, 0, 10);
    `CHK("stuck low", 4'h5, st)
    step(1, 1, 10);
    `CHK("stuck high", 4'h5, st)
    $display("fault done");
    @(negedge ref_clk);
    rst = 1;
    repeat (2) @(negedge ref_clk);
    rst = 0;
    #1;
    `CHK("power cycle", 4'h4, st)
    step(1, 1, 10);
    `CHK("rerun", 4'h8, st)
    $display("reset done");
    final_report();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
